// *** rtl/cad_alu.sv ***
// ALU, bit, shift, multiply and divide datapath of the CPU core
//
// Notes on behaviour
// - Add word or byte, optionally with carry
// - Subtract word or byte, optionally with borrow
// - Signed or unsigned 16 by 16 multiply
// - Divide low muldiv word by register
// - Long divide full muldiv register by register
// - Ones complement of word or byte
// - Twos complement negation of word or byte
// - Bitwise AND, OR, XOR word or byte
// - Copy bit, optionally inverted, to bit
// - AND, OR, XOR bit into destination bit
// - Compare two bits, flags only
// - Masked modify of high or low byte
// - Compare word or byte, flags only
// - Compare then decrement by one or two
// - Compare then increment by one or two
// - Count shifts needed to normalize word
// - Logical shift left or right, zero fill
// - Rotate left or right
// - Arithmetic right shift keeps sign
`timescale 1ns/10ps
module cad_alu (
  input  wire logic            clk_sys,
  input  wire logic            nrst,
  input  wire logic            start,
  input  wire cad_pkg::cad_op_t op,
  input  wire logic            byte_mode,
  input  wire logic [15:0]     opa,
  input  wire logic [15:0]     opb,
  input  wire logic [3:0]      src_pos,
  input  wire logic [3:0]      dst_pos,
  input  wire logic            field_hi,
  input  wire logic            carry_in,
  input  wire logic [31:0]     muldiv_in,
  output logic [15:0]          result,
  output logic                 result_wr,
  output logic [31:0]          muldiv_out,
  output logic                 muldiv_wr,
  output logic                 flag_c,
  output logic                 flag_z,
  output logic                 flag_n,
  output logic                 flag_v,
  output logic                 flags_wr,
  output logic                 done,
  output logic                 busy
);

  // ****************************************
  // Operation decode
  // ****************************************
  cad_pkg::cad_state_t state;
  cad_pkg::cad_state_t next_state;

  wire go      = start && (state == cad_pkg::ST_IDLE);
  wire is_div  = (op == cad_pkg::OP_DIV) || (op == cad_pkg::OP_DIV_U);
  wire is_divl = (op == cad_pkg::OP_DIV_LONG) || (op == cad_pkg::OP_DIV_LONG_U);
  wire div_sgn = (op == cad_pkg::OP_DIV) || (op == cad_pkg::OP_DIV_LONG);
  wire byte_ok = (op <= cad_pkg::OP_SUB_BORROW) || (op >= cad_pkg::OP_INVERT
                 && op <= cad_pkg::OP_XOR) || (op == cad_pkg::OP_CMP);
  wire eff_byte = byte_mode && byte_ok;

  // ****************************************
  // Adder and subtractor
  // ****************************************
  wire        is_neg  = (op == cad_pkg::OP_NEG);
  wire [15:0] a_src   = is_neg ? cad_pkg::ZERO_WORD : opa;
  wire [15:0] b_src   = is_neg ? opa : opb;
  wire [15:0] a_x     = eff_byte ? {8'h00, a_src[7:0]} : a_src;
  wire [15:0] b_x     = eff_byte ? {8'h00, b_src[7:0]} : b_src;
  wire        use_ci  = (op == cad_pkg::OP_ADD_CARRY) || (op == cad_pkg::OP_SUB_BORROW);
  wire        ci      = use_ci && carry_in;
  wire [16:0] sum     = {1'b0, a_x} + {1'b0, b_x} + {16'h0000, ci};
  wire [16:0] diff    = {1'b0, a_x} - {1'b0, b_x} - {16'h0000, ci};
  wire        a_s     = eff_byte ? a_x[cad_pkg::SIGN_BYTE] : a_x[cad_pkg::SIGN_WORD];
  wire        b_s     = eff_byte ? b_x[cad_pkg::SIGN_BYTE] : b_x[cad_pkg::SIGN_WORD];
  wire        sum_s   = eff_byte ? sum[cad_pkg::SIGN_BYTE] : sum[cad_pkg::SIGN_WORD];
  wire        diff_s  = eff_byte ? diff[cad_pkg::SIGN_BYTE] : diff[cad_pkg::SIGN_WORD];
  wire        sum_c   = eff_byte ? sum[cad_pkg::CARRY_BYTE] : sum[cad_pkg::CARRY_WORD];
  wire        diff_c  = eff_byte ? diff[cad_pkg::CARRY_BYTE] : diff[cad_pkg::CARRY_WORD];
  wire        sum_v   = (a_s == b_s) && (sum_s != a_s);
  wire        diff_v  = (a_s != b_s) && (diff_s != a_s);

  // ****************************************
  // Multiplier
  // ****************************************
  wire        mul_sgn = (op == cad_pkg::OP_MUL);
  wire [31:0] prod_u  = opa * opb;
  wire [31:0] prod_s  = $signed({{16{opa[15]}}, opa}) * $signed({{16{opb[15]}}, opb});
  wire [31:0] prod    = mul_sgn ? prod_s : prod_u;
  wire        prod_v  = mul_sgn ? (prod[31:15] != {17{prod[31]}}) : (prod[31:16] != 16'h0000);

  // ****************************************
  // Bit operations and masked byte modify
  // ****************************************
  wire        src_bit = opb[src_pos];
  wire        dst_bit = opa[dst_pos];
  wire [15:0] dst_one = 16'h0001 << dst_pos;
  wire [7:0]  fmask   = opb[15:8];
  wire [7:0]  fdata   = opb[7:0];
  wire [7:0]  fbyte   = field_hi ? opa[15:8] : opa[7:0];
  wire [7:0]  fnew    = (fbyte & ~fmask) | (fdata & fmask);
  wire [15:0] fword   = field_hi ? {fnew, opa[7:0]} : {opa[15:8], fnew};

  // ****************************************
  // Shifter and normalize count
  // ****************************************
  wire [3:0]  amt     = opb[3:0];
  wire [31:0] shl_t   = {16'h0000, opa} << amt;
  wire [31:0] shr_t   = {opa, 16'h0000} >> amt;
  wire [31:0] asr_t   = 32'($signed({opa, 16'h0000}) >>> amt);
  wire [31:0] rol_t   = {opa, opa} << amt;
  wire [31:0] ror_t   = {opa, opa} >> amt;
  wire        amt_nz  = (amt != 4'h0);

  function automatic logic [15:0] norm_count(input logic [15:0] w);
    logic [15:0] n;
    logic        hit;
    n   = 16'h0000;
    hit = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      if (!hit && w[i])
      begin
        hit = 1'b1;
        n   = 16'(15 - i);
      end
    end
    return n;
  endfunction

  // ****************************************
  // Result and flag selection
  // ****************************************
  logic [15:0] next_res;
  logic [15:0] fv;
  logic        next_c;
  logic        next_v;
  logic        next_n;
  logic        next_z;
  logic        next_wr;
  logic        flags_nz;

  always_comb
  begin
    next_res = cad_pkg::ZERO_WORD;
    next_c   = 1'b0;
    next_v   = 1'b0;
    next_wr  = 1'b1;
    flags_nz = 1'b1;
    next_n   = 1'b0;
    next_z   = 1'b0;
    case (op)
      cad_pkg::OP_ADD, cad_pkg::OP_ADD_CARRY:
      begin
        next_res = sum[15:0];
        next_c   = sum_c;
        next_v   = sum_v;
      end
      cad_pkg::OP_SUB, cad_pkg::OP_SUB_BORROW, cad_pkg::OP_NEG:
      begin
        next_res = diff[15:0];
        next_c   = diff_c;
        next_v   = diff_v;
      end
      cad_pkg::OP_CMP:
      begin
        next_res = diff[15:0];
        next_c   = diff_c;
        next_v   = diff_v;
        next_wr  = 1'b0;
      end
      cad_pkg::OP_CMP_DEC1, cad_pkg::OP_CMP_DEC2:
      begin
        next_res = diff[15:0];
        next_c   = diff_c;
        next_v   = diff_v;
      end
      cad_pkg::OP_CMP_INC1, cad_pkg::OP_CMP_INC2:
      begin
        next_res = diff[15:0];
        next_c   = diff_c;
        next_v   = diff_v;
      end
      cad_pkg::OP_MUL, cad_pkg::OP_MUL_U:
      begin
        next_res = prod[15:0];
        next_v   = prod_v;
        next_wr  = 1'b0;
      end
      cad_pkg::OP_INVERT: next_res = ~opa;
      cad_pkg::OP_AND:    next_res = opa & opb;
      cad_pkg::OP_OR:     next_res = opa | opb;
      cad_pkg::OP_XOR:    next_res = opa ^ opb;
      cad_pkg::OP_BIT_CLR:  next_res = opa & ~dst_one;
      cad_pkg::OP_BIT_SET:  next_res = opa | dst_one;
      cad_pkg::OP_BIT_COPY:
        next_res = src_bit ? (opa | dst_one) : (opa & ~dst_one);
      cad_pkg::OP_BIT_COPYN:
        next_res = src_bit ? (opa & ~dst_one) : (opa | dst_one);
      cad_pkg::OP_BIT_AND:
        next_res = (src_bit & dst_bit) ? opa : (opa & ~dst_one);
      cad_pkg::OP_BIT_OR:
        next_res = (src_bit | dst_bit) ? (opa | dst_one) : opa;
      cad_pkg::OP_BIT_XOR:
        next_res = (src_bit ^ dst_bit) ? (opa | dst_one) : (opa & ~dst_one);
      cad_pkg::OP_BIT_CMP:
      begin
        next_res = opa;
        next_wr  = 1'b0;
      end
      cad_pkg::OP_BFIELD: next_res = fword;
      cad_pkg::OP_NORM:   next_res = norm_count(opa);
      cad_pkg::OP_SHL:
      begin
        next_res = shl_t[15:0];
        next_c   = shl_t[16];
      end
      cad_pkg::OP_SHR:
      begin
        next_res = shr_t[31:16];
        next_c   = amt_nz && shr_t[15];
      end
      cad_pkg::OP_ROL:
      begin
        next_res = rol_t[31:16];
        next_c   = amt_nz && rol_t[16];
      end
      cad_pkg::OP_ROR:
      begin
        next_res = ror_t[15:0];
        next_c   = amt_nz && ror_t[15];
      end
      cad_pkg::OP_SHR_ARITH:
      begin
        next_res = asr_t[31:16];
        next_c   = amt_nz && asr_t[15];
      end
      default:
      begin
        next_wr  = 1'b0;
        flags_nz = 1'b0;
      end
    endcase
    fv = eff_byte ? {8'h00, next_res[7:0]} : next_res;
    if (op >= cad_pkg::OP_BIT_CLR && op <= cad_pkg::OP_BIT_CMP)
    begin
      next_z = ~dst_bit;
      next_n = src_bit ^ dst_bit;
      next_c = src_bit & dst_bit;
      next_v = src_bit | dst_bit;
    end
    else if (flags_nz)
    begin
      next_z = (fv == cad_pkg::ZERO_WORD);
      next_n = eff_byte ? fv[cad_pkg::SIGN_BYTE] : fv[cad_pkg::SIGN_WORD];
    end
    if (op == cad_pkg::OP_CMP_DEC1) next_res = opa - cad_pkg::STEP_ONE;
    if (op == cad_pkg::OP_CMP_DEC2) next_res = opa - cad_pkg::STEP_TWO;
    if (op == cad_pkg::OP_CMP_INC1) next_res = opa + cad_pkg::STEP_ONE;
    if (op == cad_pkg::OP_CMP_INC2) next_res = opa + cad_pkg::STEP_TWO;
    if (eff_byte) next_res = {opa[15:8], next_res[7:0]};
  end

  // ****************************************
  // Divide control
  // ****************************************
  wire [31:0] dvd_raw  = is_divl ? muldiv_in : (div_sgn ? {{16{muldiv_in[15]}}, muldiv_in[15:0]}
                                                          : {16'h0000, muldiv_in[15:0]});
  wire        dvd_neg  = div_sgn && dvd_raw[31];
  wire        dvs_neg  = div_sgn && opa[15];
  wire [31:0] dvd_abs  = dvd_neg ? (cad_pkg::ZERO_LONG - dvd_raw) : dvd_raw;
  wire [15:0] dvs_abs  = dvs_neg ? (cad_pkg::ZERO_WORD - opa) : opa;
  wire        div_go   = go && (is_div || is_divl);
  wire        div_done;
  wire [31:0] div_quot;
  wire [15:0] div_rem;
  logic       q_neg;
  logic       r_neg;
  logic       sgn_div;
  logic       dvs_zero;

  cad_div u_div (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .start    (div_go),
    .dividend (dvd_abs),
    .divisor  (dvs_abs),
    .done     (div_done),
    .quot     (div_quot),
    .rem      (div_rem)
  );

  wire [31:0] q_fix  = q_neg ? (cad_pkg::ZERO_LONG - div_quot) : div_quot;
  wire [15:0] r_fix  = r_neg ? (cad_pkg::ZERO_WORD - div_rem) : div_rem;
  wire        q_big  = sgn_div ? (div_quot > (q_neg ? cad_pkg::SMIN_QUOT : cad_pkg::SMAX_QUOT))
                               : (div_quot > cad_pkg::UMAX_QUOT);
  wire        div_v  = dvs_zero || q_big;

  always_comb
  begin
    next_state = state;
    case (state)
      cad_pkg::ST_IDLE: if (div_go) next_state = cad_pkg::ST_DIV;
      cad_pkg::ST_DIV:  if (div_done) next_state = cad_pkg::ST_IDLE;
      default:          next_state = cad_pkg::ST_IDLE;
    endcase
  end

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      state      <= cad_pkg::ST_IDLE;
      result     <= 16'h0000;
      result_wr  <= 1'b0;
      muldiv_out <= 32'h0000_0000;
      muldiv_wr  <= 1'b0;
      {flag_c, flag_z, flag_n, flag_v} <= 4'h0;
      flags_wr   <= 1'b0;
      done       <= 1'b0;
      busy       <= 1'b0;
      {q_neg, r_neg, sgn_div, dvs_zero} <= 4'h0;
    end
    else
    begin
      state     <= next_state;
      busy      <= (next_state == cad_pkg::ST_DIV);
      result_wr <= 1'b0;
      muldiv_wr <= 1'b0;
      flags_wr  <= 1'b0;
      done      <= 1'b0;
      if (div_go)
      begin
        q_neg    <= dvd_neg ^ dvs_neg;
        r_neg    <= dvd_neg;
        sgn_div  <= div_sgn;
        dvs_zero <= (opa == cad_pkg::ZERO_WORD);
      end
      else if (go)
      begin
        result    <= next_res;
        result_wr <= next_wr;
        {flag_c, flag_z, flag_n, flag_v} <= {next_c, next_z, next_n, next_v};
        flags_wr  <= 1'b1;
        done      <= 1'b1;
        if (op == cad_pkg::OP_MUL || op == cad_pkg::OP_MUL_U)
        begin
          muldiv_out <= prod;
          muldiv_wr  <= 1'b1;
        end
      end
      else if (state == cad_pkg::ST_DIV && div_done)
      begin
        result     <= q_fix[15:0];
        muldiv_out <= {r_fix, q_fix[15:0]};
        muldiv_wr  <= 1'b1;
        {flag_c, flag_z, flag_n, flag_v} <= {1'b0, q_fix[15:0] == cad_pkg::ZERO_WORD,
                                             q_fix[15], div_v};
        flags_wr   <= 1'b1;
        done       <= 1'b1;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  localparam int DIV_MAX = 40;
  wire [15:0] exp_add = opa + opb;
  wire [15:0] exp_neg = 16'h0000 - opa;
  wire [15:0] exp_set = opa | (16'h0001 << dst_pos);
  wire [31:0] exp_mul = opa * opb;
  wire        exp_bor = opa < opb;
  wire        w_go    = go && !byte_mode;

  add_word_a: assert property (w_go && op == cad_pkg::OP_ADD |=>
    result == $past(exp_add) && result_wr) else $error("add result wrong");
  sub_borrow_a: assert property (w_go && op == cad_pkg::OP_SUB |=>
    flag_c == $past(exp_bor)) else $error("sub borrow wrong");
  mul_unsigned_a: assert property (go && op == cad_pkg::OP_MUL_U |=>
    muldiv_out == $past(exp_mul) && muldiv_wr) else $error("mul wrong");
  div_finish_a: assert property (div_go |-> ##[2:DIV_MAX] done) else $error("div late");
  div_busy_a: assert property (div_go |=> busy [*8]) else $error("div not busy");
  neg_word_a: assert property (w_go && op == cad_pkg::OP_NEG |=>
    result == $past(exp_neg)) else $error("neg wrong");
  bit_set_a: assert property (go && op == cad_pkg::OP_BIT_SET |=>
    result == $past(exp_set)) else $error("bit set wrong");
  cmp_nowrite_a: assert property (go && op == cad_pkg::OP_CMP |=>
    !result_wr && flags_wr) else $error("cmp wrote result");
  zero_flag_a: assert property (w_go && op == cad_pkg::OP_XOR && opa == opb |=>
    flag_z && !flag_n) else $error("zero flag wrong");

  add_seen_c: cover property (go && op == cad_pkg::OP_ADD_CARRY && carry_in);
  div_long_c: cover property (div_go && is_divl ##[2:DIV_MAX] done);
  shift_c: cover property (go && op == cad_pkg::OP_SHR_ARITH && opa[15]);
  byte_c: cover property (go && byte_mode && op == cad_pkg::OP_SUB);

endmodule

// *** rtl/cad_pkg.sv ***
// Package: operation codes, states and constants of the ALU datapath
package cad_pkg;

  typedef enum logic [5:0] {
    OP_ADD        = 6'h00,
    OP_ADD_CARRY  = 6'h01,
    OP_SUB        = 6'h02,
    OP_SUB_BORROW = 6'h03,
    OP_MUL        = 6'h04,
    OP_MUL_U      = 6'h05,
    OP_DIV        = 6'h06,
    OP_DIV_U      = 6'h07,
    OP_DIV_LONG   = 6'h08,
    OP_DIV_LONG_U = 6'h09,
    OP_INVERT     = 6'h0a,
    OP_NEG        = 6'h0b,
    OP_AND        = 6'h0c,
    OP_OR         = 6'h0d,
    OP_XOR        = 6'h0e,
    OP_BIT_CLR    = 6'h0f,
    OP_BIT_SET    = 6'h10,
    OP_BIT_COPY   = 6'h11,
    OP_BIT_COPYN  = 6'h12,
    OP_BIT_AND    = 6'h13,
    OP_BIT_OR     = 6'h14,
    OP_BIT_XOR    = 6'h15,
    OP_BIT_CMP    = 6'h16,
    OP_BFIELD     = 6'h17,
    OP_CMP        = 6'h18,
    OP_CMP_DEC1   = 6'h19,
    OP_CMP_DEC2   = 6'h1a,
    OP_CMP_INC1   = 6'h1b,
    OP_CMP_INC2   = 6'h1c,
    OP_NORM       = 6'h1d,
    OP_SHL        = 6'h1e,
    OP_SHR        = 6'h1f,
    OP_ROL        = 6'h20,
    OP_ROR        = 6'h21,
    OP_SHR_ARITH  = 6'h22
  } cad_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01
  } cad_state_t;

  localparam logic [5:0]  DIV_STEPS  = 6'h20;
  localparam logic [15:0] STEP_ONE   = 16'h0001;
  localparam logic [15:0] STEP_TWO   = 16'h0002;
  localparam logic [15:0] ZERO_WORD  = 16'h0000;
  localparam logic [31:0] ZERO_LONG  = 32'h0000_0000;
  localparam logic [31:0] UMAX_QUOT  = 32'h0000_ffff;
  localparam logic [31:0] SMAX_QUOT  = 32'h0000_7fff;
  localparam logic [31:0] SMIN_QUOT  = 32'h0000_8000;
  localparam int          SIGN_WORD  = 15;
  localparam int          SIGN_BYTE  = 7;
  localparam int          CARRY_WORD = 16;
  localparam int          CARRY_BYTE = 8;

endpackage

// *** rtl/cad_div.sv ***
// Unsigned restoring divider, 32-bit dividend over 16-bit divisor
`timescale 1ns/10ps
module cad_div (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic [31:0] dividend,
  input  wire logic [15:0] divisor,
  output logic             done,
  output logic [31:0]      quot,
  output logic [15:0]      rem
);

  logic [5:0]  count;
  logic        running;
  wire  [16:0] shifted = {rem, quot[31]};
  wire  [16:0] trial   = shifted - {1'b0, divisor};
  wire         fits    = ~trial[16];
  wire  [16:0] next_rem = fits ? trial : shifted;

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      count   <= 6'h00;
      running <= 1'b0;
      done    <= 1'b0;
      quot    <= 32'h0000_0000;
      rem     <= 16'h0000;
    end
    else if (start)
    begin
      count   <= cad_pkg::DIV_STEPS;
      running <= 1'b1;
      done    <= 1'b0;
      quot    <= dividend;
      rem     <= 16'h0000;
    end
    else if (running)
    begin
      quot    <= {quot[30:0], fits};
      rem     <= next_rem[15:0];
      count   <= count - 6'h01;
      running <= (count != 6'h01);
      done    <= (count == 6'h01);
    end
    else
    begin
      done <= 1'b0;
    end
  end

endmodule

// *** bench/cad_rf_model.sv ***
// Register file model taking write-backs and feeding the multiply/divide register
`timescale 1ns/10ps
module cad_rf_model (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [15:0] result,
  input  wire logic        result_wr,
  input  wire logic [31:0] muldiv_out,
  input  wire logic        muldiv_wr,
  input  wire logic        load_en,
  input  wire logic [31:0] load_val,
  output logic      [31:0] muldiv_in,
  output logic      [15:0] gpr
);
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      muldiv_in <= 32'h0000_0000;
      gpr       <= 16'h0000;
    end
    else
    begin
      if (load_en)
        muldiv_in <= load_val;
      else if (muldiv_wr)
        muldiv_in <= muldiv_out;
      if (result_wr)
        gpr <= result;
    end
  end
endmodule

// *** bench/testbench.sv ***
// Self-checking testbench of the ALU datapath
`timescale 1ns/10ps
module testbench;
  logic             clk_sys = 1'b0;
  logic             nrst = 1'b0;
  logic             start = 1'b0;
  cad_pkg::cad_op_t op = cad_pkg::OP_ADD;
  logic             byte_mode = 1'b0;
  logic [15:0]      opa = 16'h0000;
  logic [15:0]      opb = 16'h0000;
  logic [3:0]       src_pos = 4'h0;
  logic [3:0]       dst_pos = 4'h0;
  logic             field_hi = 1'b0;
  logic             carry_in = 1'b0;
  logic             load_en = 1'b0;
  logic [31:0]      load_val = 32'h0000_0000;
  logic [31:0]      muldiv_in;
  logic [31:0]      muldiv_out;
  logic [15:0]      result;
  logic [15:0]      gpr;
  logic             result_wr;
  logic             muldiv_wr;
  logic             flag_c;
  logic             flag_z;
  logic             flag_n;
  logic             flag_v;
  logic             flags_wr;
  logic             done;
  logic             busy;
  logic             s_rwr;
  logic [3:0]       s_fl;
  int               failures = 0;
  int               cmp_count = 0;

  always #5 clk_sys = ~clk_sys;

  cad_alu uut (.clk_sys(clk_sys), .nrst(nrst), .start(start), .op(op), .byte_mode(byte_mode),
    .opa(opa), .opb(opb), .src_pos(src_pos), .dst_pos(dst_pos), .field_hi(field_hi),
    .carry_in(carry_in), .muldiv_in(muldiv_in), .result(result), .result_wr(result_wr),
    .muldiv_out(muldiv_out), .muldiv_wr(muldiv_wr), .flag_c(flag_c), .flag_z(flag_z),
    .flag_n(flag_n), .flag_v(flag_v), .flags_wr(flags_wr), .done(done), .busy(busy));

  cad_rf_model rf (.clk_sys(clk_sys), .nrst(nrst), .result(result), .result_wr(result_wr),
    .muldiv_out(muldiv_out), .muldiv_wr(muldiv_wr), .load_en(load_en), .load_val(load_val),
    .muldiv_in(muldiv_in), .gpr(gpr));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic mode(input logic b, input logic [3:0] sp, input logic [3:0] dp,
                      input logic fh, input logic ci);
    byte_mode = b;
    src_pos = sp;
    dst_pos = dp;
    field_hi = fh;
    carry_in = ci;
  endtask

  // Present one request, ends at the falling edge after the taking edge
  task automatic issue(input cad_pkg::cad_op_t o, input logic [15:0] a, input logic [15:0] b);
    @(negedge clk_sys);
    start = 1'b1;
    op = o;
    opa = a;
    opb = b;
    @(negedge clk_sys);
    start = 1'b0;
  endtask

  task automatic go(input cad_pkg::cad_op_t o, input logic [15:0] a, input logic [15:0] b);
    issue(o, a, b);
    s_rwr = result_wr;
    s_fl = {flag_c, flag_z, flag_n, flag_v};
    check("done", done, 32'h0000_0001);
    check("flags_wr", flags_wr, 32'h0000_0001);
    @(negedge clk_sys);
  endtask

  task automatic op_r(input cad_pkg::cad_op_t o, input logic [15:0] a, input logic [15:0] b,
                      input logic [15:0] er);
    go(o, a, b);
    check("result_wr", s_rwr, 32'h0000_0001);
    check("result", gpr, {16'h0000, er});
  endtask

  task automatic div(input cad_pkg::cad_op_t o, input logic [31:0] md, input logic [15:0] d,
                     input logic [31:0] em);
    int n;
    @(negedge clk_sys);
    load_en = 1'b1;
    load_val = md;
    @(negedge clk_sys);
    load_en = 1'b0;
    issue(o, d, 16'h0000);
    n = 1;
    while (done !== 1'b1 && n < 40)
    begin
      if (n == 2)
        check("busy", busy, 32'h0000_0001);
      if (n == 3)
        start = 1'b1;
      if (n == 4)
        start = 1'b0;
      @(negedge clk_sys);
      n++;
    end
    start = 1'b0;
    if (n >= 40)
    begin
      failures++;
      report_and_stop();
    end
    check("div_cycles", n, 32'h0000_0022);
    check("busy_end", busy, 32'h0000_0000);
    check("quotient", result, {16'h0000, em[15:0]});
    check("div_cv", {flag_c, flag_v}, 32'h0000_0000);
    check("div_zn", {flag_z, flag_n}, {30'h0000_0000, em[15:0] == 16'h0000, em[15]});
    @(negedge clk_sys);
    check("muldiv", muldiv_in, em);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_arith;
    mode(1'b0, 4'h0, 4'h0, 1'b0, 1'b0);
    op_r(cad_pkg::OP_ADD, 16'hffff, 16'h0001, 16'h0000);
    check("flags", s_fl, 32'h0000_000c);
    mode(1'b1, 4'h0, 4'h0, 1'b0, 1'b0);
    op_r(cad_pkg::OP_ADD, 16'h12f0, 16'h0020, 16'h1210);
    check("flags", s_fl, 32'h0000_0008);
    mode(1'b0, 4'h0, 4'h0, 1'b0, 1'b1);
    op_r(cad_pkg::OP_ADD_CARRY, 16'h7fff, 16'h0000, 16'h8000);
    check("flags", s_fl, 32'h0000_0003);
    op_r(cad_pkg::OP_SUB_BORROW, 16'h0005, 16'h0002, 16'h0002);
    mode(1'b1, 4'h0, 4'h0, 1'b0, 1'b1);
    op_r(cad_pkg::OP_SUB_BORROW, 16'h3400, 16'h0000, 16'h34ff);
    check("flags", s_fl, 32'h0000_000a);
    mode(1'b0, 4'h0, 4'h0, 1'b0, 1'b0);
    op_r(cad_pkg::OP_SUB, 16'h0000, 16'h0001, 16'hffff);
    check("flags", s_fl, 32'h0000_000a);
    $display("arith test done");
  endtask

  task automatic t_logic;
    op_r(cad_pkg::OP_AND, 16'hf0f0, 16'h3c3c, 16'h3030);
    op_r(cad_pkg::OP_OR, 16'hf0f0, 16'h3c3c, 16'hfcfc);
    op_r(cad_pkg::OP_XOR, 16'hf0f0, 16'h3c3c, 16'hcccc);
    op_r(cad_pkg::OP_INVERT, 16'h00ff, 16'h0000, 16'hff00);
    check("flags", s_fl, 32'h0000_0002);
    op_r(cad_pkg::OP_NEG, 16'h0001, 16'h0000, 16'hffff);
    mode(1'b1, 4'h0, 4'h0, 1'b0, 1'b0);
    op_r(cad_pkg::OP_AND, 16'hab0f, 16'h00f1, 16'hab01);
    op_r(cad_pkg::OP_INVERT, 16'h1234, 16'h0000, 16'h12cb);
    op_r(cad_pkg::OP_NEG, 16'h5601, 16'h0000, 16'h56ff);
    $display("logic test done");
  endtask

  task automatic t_muldiv;
    mode(1'b0, 4'h0, 4'h0, 1'b0, 1'b0);
    go(cad_pkg::OP_MUL, 16'hfffe, 16'h0003);
    check("product", muldiv_in, 32'hffff_fffa);
    check("result_wr", s_rwr, 32'h0000_0000);
    go(cad_pkg::OP_MUL_U, 16'hfffe, 16'h0003);
    check("product", muldiv_in, 32'h0002_fffa);
    div(cad_pkg::OP_DIV_U, 32'h0000_0064, 16'h0007, 32'h0002_000e);
    div(cad_pkg::OP_DIV, 32'h0000_ff9c, 16'h0007, 32'hfffe_fff2);
    div(cad_pkg::OP_DIV_LONG_U, 32'h0001_0000, 16'h0002, 32'h0000_8000);
    div(cad_pkg::OP_DIV_LONG, 32'hffff_ff9c, 16'h0007, 32'hfffe_fff2);
    $display("muldiv test done");
  endtask

  task automatic t_bits;
    mode(1'b0, 4'h5, 4'h3, 1'b0, 1'b0);
    op_r(cad_pkg::OP_BIT_COPY, 16'h0000, 16'h0020, 16'h0008);
    op_r(cad_pkg::OP_BIT_COPYN, 16'h0008, 16'h0020, 16'h0000);
    op_r(cad_pkg::OP_BIT_OR, 16'h0000, 16'h0020, 16'h0008);
    op_r(cad_pkg::OP_BIT_XOR, 16'h0008, 16'h0020, 16'h0000);
    op_r(cad_pkg::OP_BIT_AND, 16'hffff, 16'h0000, 16'hfff7);
    go(cad_pkg::OP_BIT_CMP, 16'h0008, 16'h0020);
    check("result_wr", s_rwr, 32'h0000_0000);
    check("flags", s_fl, 32'h0000_0009);
    mode(1'b0, 4'h5, 4'hf, 1'b1, 1'b0);
    op_r(cad_pkg::OP_BIT_SET, 16'h0000, 16'h0000, 16'h8000);
    op_r(cad_pkg::OP_BFIELD, 16'h1234, 16'hf0a5, 16'ha234);
    mode(1'b0, 4'h5, 4'h0, 1'b0, 1'b0);
    op_r(cad_pkg::OP_BIT_CLR, 16'hffff, 16'h0020, 16'hfffe);
    op_r(cad_pkg::OP_BFIELD, 16'h1234, 16'hf0a5, 16'h12a4);
    $display("bit test done");
  endtask

  task automatic t_cmp_shift;
    go(cad_pkg::OP_CMP, 16'h0005, 16'h0005);
    check("result_wr", s_rwr, 32'h0000_0000);
    check("flags", s_fl, 32'h0000_0004);
    mode(1'b1, 4'h0, 4'h0, 1'b0, 1'b0);
    go(cad_pkg::OP_CMP, 16'h0180, 16'h0001);
    check("flags", s_fl, 32'h0000_0001);
    mode(1'b0, 4'h0, 4'h0, 1'b0, 1'b0);
    op_r(cad_pkg::OP_CMP_DEC1, 16'h0010, 16'h0000, 16'h000f);
    op_r(cad_pkg::OP_CMP_DEC2, 16'h0010, 16'h0000, 16'h000e);
    op_r(cad_pkg::OP_CMP_INC1, 16'h0010, 16'h0000, 16'h0011);
    op_r(cad_pkg::OP_CMP_INC2, 16'h0010, 16'h0000, 16'h0012);
    op_r(cad_pkg::OP_NORM, 16'h0100, 16'h0000, 16'h0007);
    op_r(cad_pkg::OP_NORM, 16'h0001, 16'h0000, 16'h000f);
    op_r(cad_pkg::OP_SHL, 16'h8001, 16'h0001, 16'h0002);
    check("flags", s_fl, 32'h0000_0008);
    op_r(cad_pkg::OP_SHR, 16'h8001, 16'h0001, 16'h4000);
    op_r(cad_pkg::OP_ROL, 16'h8001, 16'h0004, 16'h0018);
    op_r(cad_pkg::OP_ROR, 16'h8001, 16'h0004, 16'h1800);
    op_r(cad_pkg::OP_SHR_ARITH, 16'h8000, 16'h0003, 16'hf000);
    $display("compare and shift test done");
  endtask

  initial
  begin
    repeat (10) @(negedge clk_sys);
    nrst = 1'b1;
    t_arith();
    t_logic();
    t_muldiv();
    t_bits();
    t_cmp_shift();
    report_and_stop();
  end
endmodule
